// ===== dv/asp_host_model.sv
/* Behavioural host that masters the serial link of the port.
   Assumes the bench calls frame() and owns all other pins. */
`timescale 1ns/1ps
module asp_host_model (
    // Link pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic din_o,
    output logic daisy_o,
    input wire logic dout_i,
    input wire logic dout_oe_i
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        din_o = 1'b0;
        daisy_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit i of got is the output seen at falling edge i, or z when the
    // port is not driving; bit 255 is the enable seen before the clocks.
    task automatic frame(input int nbits, input logic sel,
                         input logic [7:0] cmd, input logic [15:0] chain,
                         output logic [255:0] got);
        got = '0;
        // Keeps every pin change off the system clock edges.
        #0.25;
        cs_n_o = !sel;
        #40;
        got[255] = dout_oe_i;
        for (int i = 0; i < nbits; i++) begin
            sclk_o = 1'b1;
            din_o = cmd[7 - i % 8];
            #32;
            got[i] = (dout_oe_i === 1'b1) ? dout_i : 1'bz;
            sclk_o = 1'b0;
            #5;
            daisy_o = (i < 16) ? chain[i] : !daisy_o;
            #27;
        end
        #8;
        cs_n_o = 1'b1;
        din_o = !din_o;
        daisy_o = !daisy_o;
        #40;
    endtask: frame
endmodule: asp_host_model

// ===== dv/testbench.sv
/* Self-checking bench for the serial port: frames in every mode,
   chained data, idle clocks, power-down, reset pin and strap.
   Assumes the host model drives the link pins. */
`timescale 1ns/1ps
module testbench;
    import asp_pkg::*;
    logic clk_i, sys_rst_i, cs_n, sclk, din, daisy, dout, dout_oe;
    logic reset_n, power_down_n, spare_strap, ready_n, daisy_en, res24;
    logic sample_valid, cmd_valid, powered_down, strap_fault;
    logic [1:0] ch_sel;
    asp_frame_t sample_data;
    logic [CMD_W-1:0] cmd_byte, last_cmd;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_cmd = 0;
    int cycles = 0;

    asp_serial_port asp_serial_port_inst (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
        .daisy_in_i(daisy), .dout_o(dout), .dout_oe_o(dout_oe),
        .reset_n_i(reset_n), .power_down_n_i(power_down_n),
        .spare_strap_i(spare_strap), .sample_ready_n_o(ready_n),
        .daisy_en_i(daisy_en), .ch_sel_i(ch_sel), .res24_i(res24),
        .sample_valid_i(sample_valid), .sample_data_i(sample_data),
        .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
        .powered_down_o(powered_down), .strap_fault_o(strap_fault));
    asp_host_model asp_host_model_inst (.cs_n_o(cs_n), .sclk_o(sclk),
        .din_o(din), .daisy_o(daisy), .dout_i(dout), .dout_oe_i(dout_oe));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = !clk_i;
    end

    // Counts received bytes and cuts a hang short.
    always @(posedge clk_i) begin
        cycles++;
        if (cmd_valid === 1'b1) begin
            n_cmd++;
            last_cmd = cmd_byte;
        end
        if (cycles == 60000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask: print_verdict

    task automatic check(input logic [255:0] got, input logic [255:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask: check

    task automatic wait_clk(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask: wait_clk

    ////////////////////////////////////////////////////////////////////////
    // One read with a fresh sample; chained bits follow when enabled.
    task automatic t_frame(input logic [1:0] ch, input logic r24,
                           input logic den, input logic [7:0] k);
        logic [223:0] pat;
        logic [255:0] got;
        logic [255:0] exp;
        logic [15:0] chain;
        int n;
        chain = 16'h5A3C;
        pat = {7{32'hC3A51E69 ^ {4{k}}}};
        n = (ch == 2'h0 ? 4 : ch == 2'h1 ? 6 : 8) * (r24 ? 24 : 16) + 24;
        @(posedge clk_i);
        ch_sel <= ch;
        res24 <= r24;
        daisy_en <= den;
        sample_data <= pat[215:0];
        sample_valid <= 1'b1;
        @(posedge clk_i);
        sample_valid <= 1'b0;
        wait_clk(3);
        check(ready_n, 1'b0);
        n_cmd = 0;
        asp_host_model_inst.frame(n + 16, 1'b1, 8'hA0 ^ k, chain, got);
        exp = '0;
        exp[255] = 1'b1;
        for (int i = 0; i < n + 16; i++) begin
            exp[i] = (i < n) ? pat[215 - i] : den & chain[i - n];
        end
        check(got, exp);
        check(n_cmd, (n + 16) / 8);
        check(last_cmd, 8'hA0 ^ k);
        check(dout_oe, 1'b0);
        check(ready_n, 1'b1);
        $display("test frame ch=%0d res24=%0d done", ch, r24);
    endtask: t_frame

    // Clocks that must leave the port silent and collect no byte.
    task automatic t_silent(input logic sel);
        logic [255:0] got;
        logic [255:0] exp;
        exp = '0;
        exp[15:0] = 'z;
        n_cmd = 0;
        asp_host_model_inst.frame(16, sel, 8'h96, 16'hFFFF, got);
        check(got, exp);
        check(n_cmd, 0);
        $display("test silent select=%0d done", sel);
    endtask: t_silent

    // Power-down or reset pin held low blocks samples and traffic.
    task automatic t_quiet(input logic pd);
        @(posedge clk_i);
        power_down_n <= !pd;
        reset_n <= pd;
        wait_clk(6);
        check(powered_down, pd);
        @(posedge clk_i);
        sample_valid <= 1'b1;
        @(posedge clk_i);
        sample_valid <= 1'b0;
        wait_clk(4);
        check(ready_n, 1'b1);
        t_silent(1'b1);
        @(posedge clk_i);
        power_down_n <= 1'b1;
        reset_n <= 1'b1;
        wait_clk(6);
        check(powered_down, 1'b0);
        $display("test quiet pd=%0d done", pd);
    endtask: t_quiet

    task automatic t_strap();
        @(posedge clk_i);
        spare_strap <= 1'b1;
        wait_clk(6);
        check(strap_fault, 1'b1);
        @(posedge clk_i);
        spare_strap <= 1'b0;
        wait_clk(6);
        check(strap_fault, 1'b0);
        $display("test strap done");
    endtask: t_strap

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst_i = 1'b1;
        reset_n = 1'b1;
        power_down_n = 1'b1;
        spare_strap = 1'b0;
        daisy_en = 1'b0;
        ch_sel = 2'h0;
        res24 = 1'b0;
        sample_valid = 1'b0;
        sample_data = '0;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        wait_clk(5);
        check({dout_oe, ready_n, cmd_valid, cmd_byte, powered_down,
               strap_fault}, {2'h1, 1'b0, 8'h00, 2'h0});
        $display("test reset values done");
        for (int f = 0; f < 8; f++) begin
            t_frame(f[2:1], f[0], f[1], 8'(f * 37));
        end
        t_silent(1'b0);
        t_quiet(1'b1);
        t_quiet(1'b0);
        t_strap();
        print_verdict();
    end
endmodule: testbench

// ===== hw/asp_pin_if.sv
/*
 * Bundle of synchronised link pins and detected serial clock edges that
 * passes from the pin synchroniser to the port core.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface asp_pin_if;
    logic cs_n;
    logic sclk_rise;
    logic sclk_fall;
    logic din_prev;
    logic daisy_prev;
    logic pd_n;
    logic rst_n;
    logic strap;

    modport sync (
        output cs_n, sclk_rise, sclk_fall, din_prev, daisy_prev,
        output pd_n, rst_n, strap
    );
    modport core (
        input cs_n, sclk_rise, sclk_fall, din_prev, daisy_prev,
        input pd_n, rst_n, strap
    );
endinterface: asp_pin_if

// ===== hw/asp_pin_sync.sv
/*
 * Two-stage synchroniser for every link pin, plus serial clock edge
 * detection and a one-cycle-old copy of the data pins.
 * Assumes the pins are asynchronous to clk_i and the serial clock is
 * far slower than clk_i.
 */
`timescale 1ns/1ps
module asp_pin_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Raw pins
    input wire logic [asp_pkg::PIN_W-1:0] raw_i,
    // Synchronised view
    asp_pin_if.sync pins
);
    import asp_pkg::*;

    logic [PIN_W-1:0] meta;
    logic [PIN_W-1:0] sync;
    logic [PIN_W-1:0] prev;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= PIN_RST_VAL;
            sync <= PIN_RST_VAL;
            prev <= PIN_RST_VAL;
        end else begin
            meta <= raw_i;
            sync <= meta;
            prev <= sync;
        end
    end

    // Data pins are taken from the sample just before the detected edge.
    assign pins.cs_n = sync[PIN_CS];
    assign pins.sclk_rise = sync[PIN_SCLK] & ~prev[PIN_SCLK];
    assign pins.sclk_fall = ~sync[PIN_SCLK] & prev[PIN_SCLK];
    assign pins.din_prev = prev[PIN_DIN];
    assign pins.daisy_prev = prev[PIN_DAISY];
    assign pins.pd_n = sync[PIN_PD];
    assign pins.rst_n = sync[PIN_RST];
    assign pins.strap = sync[PIN_STRAP];

endmodule: asp_pin_sync

// ===== hw/asp_pkg.sv
/*
 * Constants, types and helpers shared by the serial port of a cascadable
 * multichannel converter: frame geometry, pin bundle layout, reset values.
 * Assumes a single 200 MHz system clock that oversamples every link pin.
 */
package asp_pkg;

    // Frame geometry.
    localparam int HDR_BITS = 24;
    localparam int MAX_CH = 8;
    localparam int RES_WIDE = 24;
    localparam int RES_NARROW = 16;
    localparam int FRAME_MAX = MAX_CH * RES_WIDE + HDR_BITS;
    localparam int LEN_W = 8;
    localparam int CMD_W = 8;

    // Channel count selection codes.
    localparam logic [1:0] CH_SEL_4 = 2'h0;
    localparam logic [1:0] CH_SEL_6 = 2'h1;
    localparam logic [1:0] CH_SEL_8 = 2'h2;

    // Pin bundle layout and its value while in reset.
    localparam int PIN_W = 7;
    localparam int PIN_CS = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_DAISY = 3;
    localparam int PIN_PD = 4;
    localparam int PIN_RST = 5;
    localparam int PIN_STRAP = 6;
    localparam logic [PIN_W-1:0] PIN_RST_VAL = 7'h31;

    // Counter reset and terminal values.
    localparam logic [2:0] BIT_CNT_RST = 3'h0;
    localparam logic [2:0] BIT_CNT_LAST = 3'h7;
    localparam logic [LEN_W-1:0] LEN_RST = 8'h00;

    typedef logic [FRAME_MAX-1:0] asp_frame_t;
    typedef enum logic [0:0] {ST_IDLE, ST_FRAME} asp_state_e;

    // Bits in one device frame for a channel count and a resolution.
    function automatic logic [LEN_W-1:0] frame_bits(input logic [1:0] ch_sel,
                                                    input logic res24);
        logic [LEN_W-1:0] chans;
        logic [LEN_W-1:0] res;
        chans = LEN_W'(MAX_CH);
        if (ch_sel == CH_SEL_4) begin
            chans = LEN_W'(4);
        end else if (ch_sel == CH_SEL_6) begin
            chans = LEN_W'(6);
        end
        res = res24 ? LEN_W'(RES_WIDE) : LEN_W'(RES_NARROW);
        return LEN_W'(chans * res + LEN_W'(HDR_BITS));
    endfunction: frame_bits

endpackage: asp_pkg

// ===== hw/asp_serial_port.sv
/*
 * Serial port of a cascadable multichannel converter: shifts a held
 * conversion frame out, passes chained data after it, collects command
 * bytes, and drives the sample-ready pin.
 * Assumes the serial clock runs well below a quarter of clk_i and that the
 * conversion side delivers frames left-aligned with a one-cycle strobe.
 */
`timescale 1ns/1ps
module asp_serial_port (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Serial link pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic daisy_in_i,
    output logic dout_o,
    output logic dout_oe_o,
    // Control pins
    input wire logic reset_n_i,
    input wire logic power_down_n_i,
    input wire logic spare_strap_i,
    output logic sample_ready_n_o,
    // Conversion side
    input wire logic daisy_en_i,
    input wire logic [1:0] ch_sel_i,
    input wire logic res24_i,
    input wire logic sample_valid_i,
    input wire asp_pkg::asp_frame_t sample_data_i,
    // Command and status
    output logic cmd_valid_o,
    output logic [asp_pkg::CMD_W-1:0] cmd_byte_o,
    output logic powered_down_o,
    output logic strap_fault_o
);
    import asp_pkg::*;

    asp_pin_if pins ();

    asp_state_e state;
    asp_frame_t hold_data;
    asp_frame_t sh;
    asp_frame_t next_sh;
    logic new_data;
    logic first_rise;
    logic [LEN_W-1:0] frame_len;
    logic [LEN_W-1:0] ins;
    logic [CMD_W-1:0] cmd_sh;
    logic [2:0] bit_cnt;
    logic soft_rst;
    logic active;
    logic cs_start;
    logic in_frame;
    logic shift_now;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser.

    asp_pin_sync u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .raw_i({spare_strap_i, reset_n_i, power_down_n_i, daisy_in_i,
                din_i, sclk_i, cs_n_i}),
        .pins(pins.sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencing.

    assign soft_rst = ~pins.rst_n;
    assign active = ~soft_rst & pins.pd_n;
    assign cs_start = (state == ST_IDLE) & ~pins.cs_n & active;
    // Gating with active keeps a reset or power-down from finishing a byte
    // in the cycle before the state machine drops back to idle.
    assign in_frame = (state == ST_FRAME) & ~pins.cs_n & active;
    // The first rising edge only opens the bit; later ones advance it.
    assign shift_now = in_frame & pins.sclk_rise & ~first_rise;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (cs_start) begin
                        state <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (pins.cs_n || !active) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion data hold and sample-ready.

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_data <= '0;
        end else if (sample_valid_i && active) begin
            hold_data <= sample_data_i;
        end
    end

    // A new sample arriving as a read starts keeps the flag set.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            new_data <= 1'b0;
        end else if (!active) begin
            new_data <= 1'b0;
        end else if (sample_valid_i) begin
            new_data <= 1'b1;
        end else if (cs_start) begin
            new_data <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sample_ready_n_o <= 1'b1;
        end else begin
            sample_ready_n_o <= ~new_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output shifter with chain insertion.

    // Chained bits enter just below the active window, so they reach the
    // output exactly when the device's own frame has run out.
    assign ins = LEN_W'(FRAME_MAX) - frame_len;

    always_comb begin
        next_sh = {sh[FRAME_MAX-2:0], 1'b0};
        next_sh[ins] = daisy_en_i & pins.daisy_prev;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sh <= '0;
            first_rise <= 1'b1;
            frame_len <= LEN_RST;
        end else if (cs_start) begin
            sh <= hold_data;
            first_rise <= 1'b1;
            frame_len <= frame_bits(ch_sel_i, res24_i);
        end else if (in_frame && pins.sclk_rise) begin
            first_rise <= 1'b0;
            if (!first_rise) begin
                sh <= next_sh;
            end
        end
    end

    assign dout_o = sh[FRAME_MAX-1];

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dout_oe_o <= 1'b0;
        end else begin
            dout_oe_o <= ~pins.cs_n & active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command byte capture.

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_sh <= '0;
            bit_cnt <= BIT_CNT_RST;
        end else if (cs_start) begin
            bit_cnt <= BIT_CNT_RST;
        end else if (in_frame && pins.sclk_fall) begin
            cmd_sh <= {cmd_sh[CMD_W-2:0], pins.din_prev};
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    // Decoding of the byte is left to the host pacing its bytes.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_valid_o <= 1'b0;
            cmd_byte_o <= '0;
        end else begin
            cmd_valid_o <= 1'b0;
            if (in_frame && pins.sclk_fall && bit_cnt == BIT_CNT_LAST) begin
                cmd_valid_o <= 1'b1;
                cmd_byte_o <= {cmd_sh[CMD_W-2:0], pins.din_prev};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status pins.

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            powered_down_o <= 1'b0;
            strap_fault_o <= 1'b0;
        end else begin
            powered_down_o <= ~pins.pd_n;
            strap_fault_o <= pins.strap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_oe_idle:
    assert property (pins.cs_n |=> !dout_oe_o)
        else $error("data output driven while select high");

    a_oe_drive:
    assert property (cs_start |=> dout_oe_o && dout_o == $past(hold_data[
        FRAME_MAX-1]))
        else $error("first bit not driven after select fell");

    a_shift_rise:
    assert property (shift_now |=> dout_o == $past(sh[FRAME_MAX-2]))
        else $error("output did not advance on rising edge");

    a_hold_fall:
    assert property (!(in_frame && pins.sclk_rise) && !cs_start
        |=> $stable(sh))
        else $error("output changed away from a rising edge");

    a_first_hold:
    assert property (in_frame && pins.sclk_rise && first_rise
        |=> $stable(sh))
        else $error("first rising edge moved the first bit");

    a_cmd_byte:
    assert property (in_frame && pins.sclk_fall && bit_cnt == BIT_CNT_LAST
        |=> cmd_valid_o && cmd_byte_o[0] == $past(pins.din_prev))
        else $error("command byte not captured on eighth falling edge");

    a_chain_ins:
    assert property (shift_now && daisy_en_i
        |=> sh[$past(ins)] == $past(pins.daisy_prev))
        else $error("chain bit not inserted behind frame");

    a_frame_len:
    assert property (cs_start && ch_sel_i == CH_SEL_8 && res24_i
        |=> frame_len == 8'hD8)
        else $error("wrong frame length for eight wide channels");

    a_len_small:
    assert property (cs_start && ch_sel_i == CH_SEL_4 && !res24_i
        |=> frame_len == 8'h58)
        else $error("wrong frame length for four narrow channels");

    a_ready_low:
    assert property (sample_valid_i && active |=> ##1 !sample_ready_n_o)
        else $error("sample-ready not asserted after new data");

    a_pd_quiet:
    assert property (!pins.pd_n |=> !dout_oe_o ##1 sample_ready_n_o)
        else $error("port active during power-down");

    a_rst_pin:
    assert property (soft_rst |=> !cmd_valid_o && !new_data
        && state == ST_IDLE)
        else $error("port not held in reset by reset pin");

    a_ready_clear:
    assert property (cs_start && !sample_valid_i |=> ##1 sample_ready_n_o)
        else $error("sample-ready not released after read start");

    a_idle_ignore:
    assert property (pins.cs_n |=> $stable(bit_cnt) && !cmd_valid_o)
        else $error("serial clock counted while select high");

    a_strap_flag:
    assert property (pins.strap |=> strap_fault_o)
        else $error("strap fault not flagged");

    a_pd_flag:
    assert property (!pins.pd_n |=> powered_down_o)
        else $error("power-down not flagged");

    c_cmd: cover property (cmd_valid_o);
    c_wide: cover property (cs_start && res24_i && ch_sel_i == CH_SEL_8);
    c_read_new: cover property (cs_start && new_data);
    c_chain: cover property (shift_now && daisy_en_i && pins.daisy_prev);
    c_pd: cover property ($rose(powered_down_o));

endmodule: asp_serial_port
